// file: rtl/psi_top.sv
// preset speed selection and inching run control with an apb slave
// assumes terminal pins asynchronous, analog reference on mclk already
// Summary of operation
// - scheme code 00 picks binary selection, 01 picks one-hot flags
// - function codes 02 to 05 on any terminal form four select bits
// - four binary select bits choose preset speed 0 to 15
// - speeds 1 to 15 output their preset table entry
// - speed 0 uses analog reference, else preset zero or panel frequency
// - binary selection accepted only after inputs stay stable for settle time
// - function codes 32 to 38 make seven speed flags for speeds 1 to 7
// - flag n selects speed n; no flag selects speed 0
// - with several flags on, the lowest numbered flag wins
// - inching input plus run command drives motor at inching frequency
// - inching frequency limited to 9.99 Hz, default 6.00 Hz
// - stop mode picks coast, ramp down or dc braking; default 04
// - modes 00 to 02 refuse inching when run came first
// - modes 03 to 05 allow inching when run came first
// - modes 03 to 05 coast if inching input drops before run
//
// Added by the designer: register access over APB and the address map.
`include "psi_cfg.svh"
`default_nettype none
module psi_top #(
   parameter int TICK_CYCLES = `PSI_TICK_CYCLES
) (
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`PSI_ADDR_W-1:0]    paddr,
   input  wire logic [31:0]               pwdata,
   output var  logic [31:0]               prdata,
   output var  logic                      pready,
   output var  logic                      pslverr,
   input  wire logic [`PSI_NUM_TERM-1:0]  terminal_pin,
   input  wire logic                      forward_run_command,
   input  wire logic                      reverse_run_command,
   input  wire psi_pkg::psi_freq_type     analog_reference,
   output var  psi_pkg::psi_freq_type     freq_out,
   output var  logic                      drive_active,
   output var  logic                      run_reverse,
   output var  logic                      stop_request,
   output var  psi_pkg::psi_stop_type     stop_method
);
   import psi_pkg::*;

   logic [1:0]              speed_select_scheme;
   logic                    ref_from_terminal;
   logic                    use_preset_zero;
   logic [7:0]              select_settle_time;
   psi_freq_type            inching_frequency;
   logic [2:0]              inching_stop_mode;
   psi_freq_type            operator_frequency_setting;
   psi_freq_type            preset_speed_zero;
   psi_freq_type            preset_speed_table [1:15];
   logic [`PSI_CODE_W-1:0]  input_function_assign [0:7];

   logic [`PSI_NUM_TERM-1:0] term;
   logic [1:0]               run_lvl;
   logic [3:0]               bin_raw;
   logic [7:1]               speed_flags;
   logic                     inching_input;
   logic [3:0]               hot_num;
   logic [3:0]               bin_last;
   logic [15:0]              tick_cnt;
   logic [7:0]               settle_cnt;
   logic                     stable_hit;
   logic [3:0]               speed_number;
   psi_freq_type             speed_freq;
   psi_state_type            state;
   psi_state_type            next_state;
   logic                     next_stop_request;
   psi_stop_type             next_stop_method;
   psi_stop_type             mode_method;
   logic                     run_any;
   logic                     run_mode;
   logic [31:0]              rd_word;
   logic                     rd_hit;
   logic [31:0]              status_word;

   psi_sync #(.WIDTH(`PSI_NUM_TERM)) u_term_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   (terminal_pin),
      .level (term)
   );

   psi_sync #(.WIDTH(2)) u_run_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   ({reverse_run_command, forward_run_command}),
      .level (run_lvl)
   );

   // ---------------- apb slave ----------------
   wire bus_wr = psel & penable & pwrite;
   wire [2:0] asg_idx = paddr[4:2];
   wire [3:0] tbl_idx = paddr[5:2];
   wire is_asg = paddr[7:5] == `PSI_ASSIGN_BASE;
   wire is_tbl = (paddr[7:6] == `PSI_TABLE_BASE) && (tbl_idx != 4'h0);

   // zero wait states: access phase always completes
   assign pready = 1'b1;

   always_ff @(posedge mclk) begin
      if (rst) begin
         speed_select_scheme        <= `PSI_SCHEME_BIN;
         ref_from_terminal          <= 1'b0;
         use_preset_zero            <= 1'b0;
         select_settle_time         <= `PSI_RST_SETTLE;
         inching_frequency          <= `PSI_RST_INCH_FREQ;
         inching_stop_mode          <= `PSI_RST_STOP_MODE;
         operator_frequency_setting <= `PSI_RST_FREQ;
         preset_speed_zero          <= `PSI_RST_PRESET0;
      end else if (bus_wr) begin
         unique case (paddr)
            `PSI_OFS_CTRL: begin
               if (pwdata[`PSI_CTRL_SCHEME_LSB +: 2] <= `PSI_SCHEME_HOT) begin
                  speed_select_scheme <= pwdata[`PSI_CTRL_SCHEME_LSB +: 2];
               end
               ref_from_terminal <= pwdata[`PSI_CTRL_REF_TERM];
               use_preset_zero   <= pwdata[`PSI_CTRL_USE_PRE0];
            end
            `PSI_OFS_SETTLE: select_settle_time <= pwdata[7:0];
            `PSI_OFS_INCH_FREQ: begin
               // clamp rather than reject so software always gets a legal value
               if (pwdata[15:0] > `PSI_MAX_INCH_FREQ) begin
                  inching_frequency <= `PSI_MAX_INCH_FREQ;
               end else begin
                  inching_frequency <= pwdata[15:0];
               end
            end
            `PSI_OFS_STOP_MODE: begin
               if (pwdata[2:0] <= `PSI_STOP_MAX && pwdata[31:3] == '0) begin
                  inching_stop_mode <= pwdata[2:0];
               end
            end
            `PSI_OFS_OPER_FREQ: operator_frequency_setting <= pwdata[15:0];
            `PSI_OFS_PRESET0: preset_speed_zero <= pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 1; i <= 15; i++) begin
            preset_speed_table[i] <= `PSI_RST_FREQ;
         end
      end else if (bus_wr && is_tbl) begin
         preset_speed_table[tbl_idx] <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < `PSI_NUM_TERM; i++) begin
            input_function_assign[i] <= `PSI_FN_NONE;
         end
      end else if (bus_wr && is_asg) begin
         input_function_assign[asg_idx] <= pwdata[`PSI_CODE_W-1:0];
      end
   end

   always_comb begin
      status_word = '0;
      status_word[`PSI_ST_SPEED_LSB +: 4] = speed_number;
      status_word[`PSI_ST_DRIVE]          = drive_active;
      status_word[`PSI_ST_INCH]           = state == PSI_INCH;
      status_word[`PSI_ST_REVERSE]        = run_reverse;
      status_word[`PSI_ST_STOP_LSB +: 3]  = stop_method;
   end

   always_comb begin
      rd_word = '0;
      rd_hit  = 1'b1;
      if (is_asg) begin
         rd_word[`PSI_CODE_W-1:0] = input_function_assign[asg_idx];
      end else if (is_tbl) begin
         rd_word[15:0] = preset_speed_table[tbl_idx];
      end else begin
         unique case (paddr)
            `PSI_OFS_CTRL: begin
               rd_word[`PSI_CTRL_SCHEME_LSB +: 2] = speed_select_scheme;
               rd_word[`PSI_CTRL_REF_TERM]        = ref_from_terminal;
               rd_word[`PSI_CTRL_USE_PRE0]        = use_preset_zero;
            end
            `PSI_OFS_SETTLE:    rd_word[7:0]  = select_settle_time;
            `PSI_OFS_INCH_FREQ: rd_word[15:0] = inching_frequency;
            `PSI_OFS_STOP_MODE: rd_word[2:0]  = inching_stop_mode;
            `PSI_OFS_OPER_FREQ: rd_word[15:0] = operator_frequency_setting;
            `PSI_OFS_PRESET0:   rd_word[15:0] = preset_speed_zero;
            `PSI_OFS_STATUS:    rd_word       = status_word;
            `PSI_OFS_FREQ_OUT:  rd_word[15:0] = freq_out;
            default:            rd_hit        = 1'b0;
         endcase
      end
   end

   // read data and error captured in the setup cycle, valid in access
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr <= !rd_hit;
      end
   end

   // ---------------- terminal function decode ----------------
   always_comb begin
      bin_raw       = '0;
      speed_flags   = '0;
      inching_input = 1'b0;
      for (int i = 0; i < `PSI_NUM_TERM; i++) begin
         if (input_function_assign[i] >= `PSI_FN_BIN0 &&
             input_function_assign[i] <= `PSI_FN_BIN3) begin
            // bit0 function lands in the lsb
            bin_raw[2'(input_function_assign[i] - `PSI_FN_BIN0)] |=
               term[i];
         end
         if (input_function_assign[i] >= `PSI_FN_FLAG1 &&
             input_function_assign[i] <= `PSI_FN_FLAG7) begin
            speed_flags[3'(input_function_assign[i] - `PSI_FN_FLAG1) + 3'h1]
               |= term[i];
         end
         if (input_function_assign[i] == `PSI_FN_INCH) begin
            inching_input |= term[i];
         end
      end
   end

   // scanning downward so the lowest active flag is the last to win
   always_comb begin
      hot_num = 4'h0;
      for (int k = 7; k >= 1; k--) begin
         if (speed_flags[k]) begin
            hot_num = 4'(k);
         end
      end
   end

   // ---------------- binary settle filter ----------------
   assign stable_hit = (bin_raw == bin_last) &&
                       (settle_cnt >= select_settle_time);

   always_ff @(posedge mclk) begin
      if (rst) begin
         bin_last   <= 4'h0;
         tick_cnt   <= '0;
         settle_cnt <= '0;
      end else if (bin_raw != bin_last) begin
         // any change restarts the wait so transient codes never apply
         bin_last   <= bin_raw;
         tick_cnt   <= '0;
         settle_cnt <= '0;
      end else if (!stable_hit) begin
         if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
            tick_cnt   <= '0;
            settle_cnt <= settle_cnt + 8'h01;
         end else begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         speed_number <= 4'h0;
      end else if (speed_select_scheme == `PSI_SCHEME_HOT) begin
         speed_number <= hot_num;
      end else if (stable_hit) begin
         speed_number <= bin_last;
      end
   end

   always_comb begin
      if (speed_number != 4'h0) begin
         speed_freq = preset_speed_table[speed_number];
      end else if (ref_from_terminal) begin
         speed_freq = analog_reference;
      end else if (use_preset_zero) begin
         speed_freq = preset_speed_zero;
      end else begin
         speed_freq = operator_frequency_setting;
      end
   end

   // ---------------- inching sequence ----------------
   assign run_any  = run_lvl[0] | run_lvl[1];
   assign run_mode = inching_stop_mode >= `PSI_STOP_RUN_MIN;

   always_comb begin
      unique case (inching_stop_mode)
         `PSI_STOP_COAST_A, `PSI_STOP_COAST_B: mode_method = `PSI_METH_COAST;
         `PSI_STOP_RAMP_A, `PSI_STOP_RAMP_B:   mode_method = `PSI_METH_RAMP;
         default:                              mode_method = `PSI_METH_DC;
      endcase
   end

   always_comb begin
      next_state        = state;
      next_stop_request = 1'b0;
      next_stop_method  = stop_method;
      unique case (state)
         PSI_IDLE: begin
            if (run_any) begin
               next_state = inching_input ? PSI_INCH : PSI_NORMAL;
            end
         end
         PSI_NORMAL: begin
            if (!run_any) begin
               next_state = PSI_IDLE;
            end else if (inching_input && run_mode) begin
               next_state = PSI_INCH;
            end
         end
         PSI_INCH: begin
            if (!run_any) begin
               next_state        = PSI_IDLE;
               next_stop_request = 1'b1;
               next_stop_method  = mode_method;
            end else if (!inching_input) begin
               next_state        = PSI_HOLD;
               next_stop_request = 1'b1;
               next_stop_method  = run_mode ? `PSI_METH_COAST
                                            : mode_method;
            end
         end
         PSI_HOLD: begin
            // stays stopped until the run command is withdrawn
            if (!run_any) begin
               next_state = PSI_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= PSI_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stop_request <= 1'b0;
         stop_method  <= `PSI_METH_NONE;
      end else begin
         stop_request <= next_stop_request;
         stop_method  <= next_stop_method;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         freq_out     <= `PSI_RST_FREQ;
         drive_active <= 1'b0;
         run_reverse  <= 1'b0;
      end else begin
         drive_active <= next_state == PSI_NORMAL || next_state == PSI_INCH;
         // forward wins when both run commands are on
         run_reverse  <= run_lvl[1] & ~run_lvl[0];
         unique case (next_state)
            PSI_INCH:   freq_out <= inching_frequency;
            PSI_NORMAL: freq_out <= speed_freq;
            default:    freq_out <= `PSI_RST_FREQ;
         endcase
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_HOT_RANGE: assert property (
      speed_select_scheme == `PSI_SCHEME_HOT |=> speed_number[3] == 1'b0)
      else $error("one-hot scheme gave a speed above 7");
   AST_BIN_SETTLE: assert property (
      speed_select_scheme == `PSI_SCHEME_BIN &&
      $past(speed_select_scheme) == `PSI_SCHEME_BIN && $changed(speed_number)
      |-> $past(stable_hit) && speed_number == $past(bin_last))
      else $error("binary speed changed before the settle time");
   AST_TABLE_FREQ: assert property (
      next_state == PSI_NORMAL && speed_number != 4'h0
      |=> freq_out == $past(preset_speed_table[speed_number]))
      else $error("preset table frequency not applied");
   AST_ZERO_ANALOG: assert property (
      next_state == PSI_NORMAL && speed_number == 4'h0 && ref_from_terminal
      |=> freq_out == $past(analog_reference))
      else $error("speed zero did not follow analog reference");
   AST_LOWEST_FLAG: assert property (
      speed_select_scheme == `PSI_SCHEME_HOT && speed_flags[1]
      |=> speed_number == 4'h1)
      else $error("lowest flag did not take priority");
   AST_NO_FLAG: assert property (
      speed_select_scheme == `PSI_SCHEME_HOT && speed_flags == 7'h00
      |=> speed_number == 4'h0)
      else $error("no flag did not give speed zero");
   AST_INCH_FREQ: assert property (
      state == PSI_INCH && $past(state) == PSI_INCH
      |-> freq_out == $past(inching_frequency) && drive_active)
      else $error("inching frequency not driven");
   AST_INCH_LIMIT: assert property (
      inching_frequency <= `PSI_MAX_INCH_FREQ)
      else $error("inching frequency above limit");
   AST_REFUSE: assert property (
      state == PSI_NORMAL && inching_input && !run_mode
      |=> state != PSI_INCH)
      else $error("inching entered although run came first");
   AST_ALLOW: assert property (
      state == PSI_NORMAL && run_any && inching_input && run_mode
      |=> state == PSI_INCH)
      else $error("inching refused in run-enabled mode");
   AST_COAST: assert property (
      state == PSI_INCH && run_any && !inching_input && run_mode
      |=> stop_request && stop_method == `PSI_METH_COAST)
      else $error("early inching release did not coast");

   COV_BIN_SELECT: cover property (
      speed_select_scheme == `PSI_SCHEME_BIN && stable_hit
      && bin_last == 4'hf);
   COV_HOT_MULTI: cover property (
      speed_select_scheme == `PSI_SCHEME_HOT && speed_flags[2]
      && speed_flags[5]);
   COV_INCH_STOP: cover property (state == PSI_INCH ##1 stop_request);
   COV_RUN_FIRST: cover property (state == PSI_NORMAL ##1 state == PSI_INCH);
endmodule : psi_top
`default_nettype wire

// file: rtl/psi_cfg.svh
// constants for the preset speed and inching select block
// assumes a single 50 MHz clock and a 32-bit apb register bus
`ifndef PSI_CFG_SVH
`define PSI_CFG_SVH

`define PSI_MCLK_HZ        50000000
`define PSI_SETTLE_UNIT_US 1000
`define PSI_TICK_CYCLES    ((`PSI_MCLK_HZ / 1000000) * `PSI_SETTLE_UNIT_US)

`define PSI_FREQ_W         16
`define PSI_CODE_W         6
`define PSI_NUM_TERM       8
`define PSI_ADDR_W         8

// register byte offsets
`define PSI_OFS_CTRL       8'h00
`define PSI_OFS_SETTLE     8'h04
`define PSI_OFS_INCH_FREQ  8'h08
`define PSI_OFS_STOP_MODE  8'h0c
`define PSI_OFS_OPER_FREQ  8'h10
`define PSI_OFS_PRESET0    8'h14
`define PSI_OFS_STATUS     8'h18
`define PSI_OFS_FREQ_OUT   8'h1c
`define PSI_ASSIGN_BASE    3'h1
`define PSI_TABLE_BASE     2'h1

// ctrl fields
`define PSI_CTRL_SCHEME_LSB 0
`define PSI_CTRL_REF_TERM   2
`define PSI_CTRL_USE_PRE0   3

// status fields
`define PSI_ST_SPEED_LSB   0
`define PSI_ST_DRIVE       4
`define PSI_ST_INCH        5
`define PSI_ST_REVERSE     6
`define PSI_ST_STOP_LSB    8

// scheme codes
`define PSI_SCHEME_BIN     2'h0
`define PSI_SCHEME_HOT     2'h1

// input function codes
`define PSI_FN_BIN0        6'h02
`define PSI_FN_BIN3        6'h05
`define PSI_FN_INCH        6'h06
`define PSI_FN_FLAG1       6'h20
`define PSI_FN_FLAG7       6'h26
`define PSI_FN_NONE        6'h3f

// inching stop mode codes
`define PSI_STOP_MAX       3'h5
`define PSI_STOP_RUN_MIN   3'h3
`define PSI_STOP_COAST_A   3'h0
`define PSI_STOP_COAST_B   3'h3
`define PSI_STOP_RAMP_A    3'h1
`define PSI_STOP_RAMP_B    3'h4

// stop method one-hot outputs
`define PSI_METH_NONE      3'h0
`define PSI_METH_COAST     3'h1
`define PSI_METH_RAMP      3'h2
`define PSI_METH_DC        3'h4

// reset values, frequencies in 0.01 Hz
`define PSI_RST_INCH_FREQ  16'h0258
`define PSI_MAX_INCH_FREQ  16'h03e7
`define PSI_RST_STOP_MODE  3'h4
`define PSI_RST_PRESET0    16'h0258
`define PSI_RST_FREQ       16'h0000
`define PSI_RST_SETTLE     8'h00

`endif

// file: rtl/psi_pkg.sv
// types shared by the preset speed and inching select block
// assumes psi_cfg.svh for the numeric constants
`default_nettype none
package psi_pkg;
   typedef logic [15:0] psi_freq_type;
   typedef logic [2:0]  psi_stop_type;
   typedef enum logic [3:0] {
      PSI_IDLE   = 4'b0001,
      PSI_NORMAL = 4'b0010,
      PSI_INCH   = 4'b0100,
      PSI_HOLD   = 4'b1000
   } psi_state_type;
endpackage : psi_pkg
`default_nettype wire

// file: rtl/psi_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin inputs; output moves when stages two and three agree
`default_nettype none
module psi_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin,
   output var  logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge mclk) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // per-bit agreement so a one-cycle glitch never reaches the level
   always_ff @(posedge mclk) begin
      if (rst) begin
         level <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               level[i] <= stage3[i];
            end
         end
      end
   end
endmodule : psi_sync
`default_nettype wire

// file: tb/psi_switches.sv
// switch and controller model driving the terminal and run pins
// assumes the bench sets wanted levels just after rising edges
`default_nettype none
module psi_switches (
   input  wire logic        mclk,
   input  wire logic [7:0]  want_pin,
   input  wire logic        want_fwd,
   input  wire logic        want_rev,
   output var  logic [7:0]  pin,
   output var  logic        fwd,
   output var  logic        rev,
   output var  logic [15:0] aref
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pin = 8'h00;
      fwd = 1'b0;
      rev = 1'b0;
      aref = 16'h1234;
   end
   // contacts follow a cycle late, so no edge race with the sampler
   always @(posedge mclk) begin
      pin <= want_pin;
      fwd <= want_fwd;
      rev <= want_rev;
   end
endmodule : psi_switches
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the preset speed and inching block
// assumes psi_switches as the pin partner and a 50 MHz clock
`include "psi_cfg.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import psi_pkg::*;
   logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0, want_pin = 0, pin;
   logic [31:0] pwdata = 0, prdata, rd_v;
   logic        pready, pslverr, err, want_fwd = 0, want_rev = 0, fwd, rev;
   logic        drive_active, run_reverse, stop_request;
   psi_freq_type aref, freq_out;
   psi_stop_type stop_method;
   int          n_errors = 0, check_count = 0, cyc = 0;
   logic [2:0]  meth [6] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4};
   always #10 mclk = ~mclk;
   psi_switches PART (.mclk(mclk), .want_pin(want_pin),
      .want_fwd(want_fwd), .want_rev(want_rev), .pin(pin), .fwd(fwd),
      .rev(rev), .aref(aref));
   psi_top #(.TICK_CYCLES(4)) DUT (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .terminal_pin(pin), .forward_run_command(fwd),
      .reverse_run_command(rev), .analog_reference(aref),
      .freq_out(freq_out), .drive_active(drive_active),
      .run_reverse(run_reverse), .stop_request(stop_request),
      .stop_method(stop_method));
   task automatic give_verdict;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd_v = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask : apb
   task automatic wfreq(input logic [15:0] exp);
      for (int i = 0; i < 80 && freq_out !== exp; i++) @(posedge mclk);
      chk(freq_out, exp);
   endtask : wfreq
   task automatic t_regs;
      apb(0, 8'h08, 0); chk(rd_v, 32'h258);
      apb(0, 8'h0c, 0); chk(rd_v, 32'h4);
      apb(1, 8'h08, 32'h7d0); apb(0, 8'h08, 0); chk(rd_v, 32'h3e7);
      apb(0, 8'h40, 0); chk(err, 1'b1);
   endtask : t_regs
   task automatic t_binary;
      for (int i = 0; i < 4; i++) apb(1, 8'h20 + 4 * i, 2 + i);
      for (int n = 1; n < 16; n++) apb(1, 8'h40 + 4 * n, 32'h100 + n);
      apb(1, 8'h04, 1);
      apb(1, 8'h10, 32'h77);
      want_fwd <= 1;
      for (int n = 15; n >= 0; n--) begin
         want_pin <= n;
         wfreq(n > 0 ? 16'h100 + n : 16'h77);
      end
      want_pin <= 8'h5; wfreq(16'h105);
      // a short burst must never reach the output
      want_pin <= 8'h6; repeat (3) @(posedge mclk); want_pin <= 8'h5;
      repeat (20) begin
         @(posedge mclk);
         chk(freq_out, 16'h105);
      end
      apb(1, 8'h00, 4); want_pin <= 0; wfreq(16'h1234);
      apb(1, 8'h00, 8); wfreq(16'h258);
   endtask : t_binary
   task automatic t_onehot;
      apb(1, 8'h00, 1);
      for (int i = 0; i < 7; i++) apb(1, 8'h20 + 4 * i, 32'h20 + i);
      apb(1, 8'h3c, 6);
      want_pin <= 8'h12; wfreq(16'h102);
      want_pin <= 8'h13; wfreq(16'h101);
      want_pin <= 8'h40; wfreq(16'h107);
      want_pin <= 8'h00; wfreq(16'h77);
      want_fwd <= 0;
      want_rev <= 1;
      repeat (8) @(posedge mclk);
      chk(run_reverse, 1'b1);
      chk(drive_active, 1'b1);
      chk(freq_out, 16'h77);
      want_rev <= 0;
      repeat (10) @(posedge mclk);
      chk(drive_active, 1'b0);
      chk(freq_out, 16'h0);
   endtask : t_onehot
   task automatic t_inch;
      for (int m = 0; m < 6; m++) begin
         apb(1, 8'h0c, m);
         want_pin <= 8'h80; repeat (2) @(posedge mclk);
         want_fwd <= 1; wfreq(16'h3e7);
         want_fwd <= 0;
         repeat (30) if (stop_request !== 1'b1) @(posedge mclk);
         chk(stop_request, 1'b1);
         repeat (2) @(posedge mclk); chk(stop_method, meth[m]);
         want_pin <= 0; repeat (10) @(posedge mclk);
      end
      for (int m = 0; m < 5; m += 4) begin
         apb(1, 8'h0c, m);
         want_fwd <= 1; wfreq(16'h77);
         want_pin <= 8'h80; repeat (12) @(posedge mclk);
         chk(freq_out, m > 2 ? 16'h3e7 : 16'h77);
         want_pin <= 0; repeat (12) @(posedge mclk);
         if (m > 2) chk(stop_method, 3'h1);
         if (m > 2) chk(drive_active, 1'b0);
         want_fwd <= 0; repeat (10) @(posedge mclk);
      end
   endtask : t_inch
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      chk(freq_out, 16'h0);
      chk(drive_active, 1'b0);
      chk(stop_method, 3'h0);
      t_regs();
      t_binary();
      t_onehot();
      t_inch();
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
